/* File: logic/dot_cfg.svh */
// constants for the dsp operand transfer unit
// Overview of operation
// [RULE_01] up to two memory transfers per instruction
// [RULE_02] transfers never touch status condition bits
// [RULE_03] parallel transfer uses 32-bit code, 16-bit words
// [RULE_04] double transfer uses 16-bit code, X/Y/both
// [RULE_05] x loads to x inputs, y loads to y inputs
// [RULE_06] memory stores source only from accumulators
// [RULE_07] word moves upper half, destination low zeroed
// [RULE_08] transfers execute regardless of operation condition
// [RULE_09] x/y transfers reach only x/y memories
// [RULE_10] single transfer: one move, never with alu
// [RULE_11] single addressing: x pointer plus two others
// [RULE_12] single transfers reach every memory area
// [RULE_13] any dsp register but status, guards independent
// [RULE_14] single uses internal buses, arbitrates with fetch
// [RULE_15] word load zero-fills low, sign-extends guard
// [RULE_16] longword moves 32 bits, guard sign-filled
// [RULE_17] guard store leaves top 24 bits undefined
// [RULE_18] word load to guard writes low byte
// [RULE_19] store right after data operation stalls once
// [RULE_20] program avoids double destination in one instruction
// [RULE_21] contended register result is undefined
// [RULE_22] status register moves only via system instructions
// [RULE_23] x and y writes land same cycle
`ifndef DOT_CFG_SVH
`define DOT_CFG_SVH
`define DOT_WORD_W 16
`define DOT_LONG_W 32
`define DOT_GUARD_W 8
`define DOT_GUARD_LSB 32
`define DOT_SIGN_BIT 31
`define DOT_UNDEF_TOP 24
`define DOT_STALL_CYCLES 1
`define DOT_RESET_REG 32'h00000000
`define DOT_RESET_GUARD 8'h00
`endif

/* File: logic/dot_pkg.sv */
// types for the dsp operand transfer unit
package dot_pkg;
    // register select for single transfers
    typedef enum logic [3:0] {
        DOT_R_XIN0, DOT_R_XIN1, DOT_R_YIN0, DOT_R_YIN1,
        DOT_R_MUL0, DOT_R_MUL1, DOT_R_ACC0, DOT_R_ACC1,
        DOT_R_GRD0, DOT_R_GRD1, DOT_R_STATUS
    } dot_reg_t;
    typedef enum logic [1:0] {DOT_XY_NONE, DOT_XY_LOAD, DOT_XY_STORE} dot_dir_t;
    typedef struct packed {
        dot_dir_t dir;
        logic sel;       // load: input reg 0/1; store: accumulator 0/1
        logic [15:0] addr;
    } dot_xy_req_t;
    typedef struct packed {
        logic valid;
        logic load;
        logic longword;
        logic [1:0] ptr;  // 0 x pointer, 1/2 added pointers, 3 y pointer
        dot_reg_t reg_sel;
    } dot_single_t;
    typedef struct packed {
        logic valid;
        logic parallel;  // 32-bit code with data operation
        logic cond_false;
        dot_xy_req_t x;
        dot_xy_req_t y;
        dot_single_t single;
        logic dataop;    // this instruction ends in the dsp stage
    } dot_instr_t;
    typedef struct packed {
        logic [7:0] guard;
        logic [31:0] data;
    } dot_acc_t;
endpackage

/* File: logic/dot_stall.sv */
// stall after data operation before store
`timescale 1ns/1ps
`include "dot_cfg.svh"
module dot_stall
    import dot_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic issue,
    input wire logic dataop,
    input wire logic is_store,
    output logic stall
);
    logic prev_op_ff;
    logic nxt_prev_op;

    always_comb begin
        stall = issue && is_store && prev_op_ff; // RULE_19
        nxt_prev_op = prev_op_ff;
        if (stall) begin
            nxt_prev_op = 1'b0;
        end else if (issue) begin
            nxt_prev_op = dataop;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_op_ff <= 1'b0;
        end else begin
            prev_op_ff <= nxt_prev_op;
        end
    end
endmodule // dot_stall

/* File: logic/dot_ext.sv */
// load data shaping: word fill and guard sign extension
`timescale 1ns/1ps
`include "dot_cfg.svh"
module dot_ext
    import dot_pkg::*;
(
    input wire logic [31:0] bus_data,
    input wire logic longword,
    output logic [31:0] reg_val,
    output logic [7:0] guard_val
);
    always_comb begin
        if (longword) begin
            reg_val = bus_data; // RULE_16
        end else begin
            reg_val = {bus_data[15:0], 16'h0000}; // RULE_15
        end
        guard_val = {`DOT_GUARD_W{reg_val[`DOT_SIGN_BIT]}};
    end
endmodule // dot_ext

/* File: logic/dot_unit.sv */
// dsp operand transfer unit top
`timescale 1ns/1ps
`include "dot_cfg.svh"
module dot_unit
    import dot_pkg::*;
#(
    parameter int XY_WORD_W = `DOT_WORD_W,
    parameter int GUARD_W = `DOT_GUARD_W
)
(
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire dot_instr_t INSTR,
    output logic STALL,
    // x and y memory ports
    output logic X_REQ,
    output logic X_WE,
    output logic [15:0] X_ADDR,
    output logic [15:0] X_WDATA,
    input wire logic [15:0] X_RDATA,
    output logic Y_REQ,
    output logic Y_WE,
    output logic [15:0] Y_ADDR,
    output logic [15:0] Y_WDATA,
    input wire logic [15:0] Y_RDATA,
    // internal bus
    input wire logic [31:0] PTR_X,
    input wire logic [31:0] PTR_A,
    input wire logic [31:0] PTR_B,
    output logic I_REQ,
    output logic I_WE,
    output logic I_LONG,
    output logic [31:0] I_ADDR,
    output logic [31:0] I_WDATA,
    input wire logic I_GRANT,
    input wire logic [31:0] I_RDATA,
    output logic I_DONE,
    output logic ILLEGAL,
    // alu result writes from the dsp stage
    input wire logic ALU_WE,
    input wire dot_reg_t ALU_DST,
    input wire logic [31:0] ALU_DATA,
    output logic [31:0] XIN0,
    output logic [31:0] XIN1,
    output logic [31:0] YIN0,
    output logic [31:0] YIN1,
    output logic [31:0] MUL0,
    output logic [31:0] MUL1,
    output dot_acc_t ACC0,
    output dot_acc_t ACC1
);
    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    logic [31:0] xin_ff [2];
    logic [31:0] yin_ff [2];
    logic [31:0] mul_ff [2];
    dot_acc_t acc_ff [2];
    logic [31:0] nxt_xin [2];
    logic [31:0] nxt_yin [2];
    logic [31:0] nxt_mul [2];
    dot_acc_t nxt_acc [2];
    logic xload_ff, yload_ff, xsel_ff, ysel_ff;
    logic nxt_xload, nxt_yload, nxt_xsel, nxt_ysel;
    typedef enum {SG_IDLE, SG_BUS} dot_sg_t;
    dot_sg_t sg_ff, nxt_sg;
    dot_single_t sreq_ff, nxt_sreq;
    logic [31:0] iaddr_ff, nxt_iaddr, iwdata_ff, nxt_iwdata;
    logic idone_ff, nxt_idone, ill_ff, nxt_ill;
    logic [31:0] ld_val;
    logic [7:0] ld_guard;
    logic any_store, issue, xy_ok;

    // --------------------------------------------------------------
    // elaboration checks
    // --------------------------------------------------------------
    // ports and register halves are fixed at one word
    // guard width must match the sign fill in dot_ext
    if (XY_WORD_W != `DOT_WORD_W || GUARD_W != `DOT_GUARD_W) begin : g_bad_width
        $error("unsupported word or guard width");
    end

    function automatic logic [31:0] reg_read(input dot_reg_t r,
        input logic [31:0] xi0, input logic [31:0] xi1,
        input logic [31:0] yi0, input logic [31:0] yi1,
        input logic [31:0] m0, input logic [31:0] m1,
        input dot_acc_t a0, input dot_acc_t a1);
        logic [31:0] v;
        v = 32'h00000000;
        unique case (r)
            DOT_R_XIN0: v = xi0;
            DOT_R_XIN1: v = xi1;
            DOT_R_YIN0: v = yi0;
            DOT_R_YIN1: v = yi1;
            DOT_R_MUL0: v = m0;
            DOT_R_MUL1: v = m1;
            DOT_R_ACC0: v = a0.data;
            DOT_R_ACC1: v = a1.data;
            // top 24 bits left as zero; software must not rely on them
            DOT_R_GRD0: v = {24'h000000, a0.guard}; // RULE_17
            DOT_R_GRD1: v = {24'h000000, a1.guard}; // RULE_17
            default: v = 32'h00000000;
        endcase
        return v;
    endfunction

    // --------------------------------------------------------------
    // issue and stall
    // --------------------------------------------------------------
    assign any_store = (INSTR.x.dir == DOT_XY_STORE) || (INSTR.y.dir == DOT_XY_STORE) ||
        (INSTR.single.valid && !INSTR.single.load);

    // single transfer holds issue while the internal bus is busy
    assign issue = INSTR.valid && (sg_ff == SG_IDLE);

    dot_stall u_stall (
        .clk(CLK_SYS),
        .reset_n(RESET_N),
        .issue(issue),
        .dataop(INSTR.dataop),
        .is_store(any_store),
        .stall(STALL)
    );

    // xy transfers are refused alongside a single one
    assign xy_ok = issue && !STALL && !INSTR.single.valid; // RULE_10

    dot_ext u_ext (
        .bus_data(I_RDATA),
        .longword(sreq_ff.longword),
        .reg_val(ld_val),
        .guard_val(ld_guard)
    );

    // --------------------------------------------------------------
    // x/y memory ports: combinational request, both in one cycle
    // --------------------------------------------------------------
    always_comb begin
        // condition of the parallel operation is ignored here
        X_REQ = xy_ok && (INSTR.x.dir != DOT_XY_NONE); // RULE_01 RULE_08 RULE_09
        Y_REQ = xy_ok && (INSTR.y.dir != DOT_XY_NONE); // RULE_01 RULE_04
        X_WE = X_REQ && (INSTR.x.dir == DOT_XY_STORE);
        Y_WE = Y_REQ && (INSTR.y.dir == DOT_XY_STORE);
        X_ADDR = INSTR.x.addr;
        Y_ADDR = INSTR.y.addr;
        // store source is an accumulator's upper word
        X_WDATA = acc_ff[INSTR.x.sel].data[31:16]; // RULE_06 RULE_07 RULE_03
        Y_WDATA = acc_ff[INSTR.y.sel].data[31:16]; // RULE_06 RULE_07
    end

    // --------------------------------------------------------------
    // single transfer sequencer
    // --------------------------------------------------------------
    always_comb begin
        nxt_sg = sg_ff;
        nxt_sreq = sreq_ff;
        nxt_iaddr = iaddr_ff;
        nxt_iwdata = iwdata_ff;
        nxt_idone = 1'b0;
        nxt_ill = 1'b0;
        unique case (sg_ff)
            SG_IDLE: begin
                if (issue && !STALL && INSTR.single.valid) begin
                    // status register and y pointer are not reachable
                    if (INSTR.single.reg_sel == DOT_R_STATUS || INSTR.single.ptr == 2'h3 ||
                        INSTR.single.reg_sel > DOT_R_STATUS) begin // RULE_22 RULE_11
                        nxt_ill = 1'b1;
                    end else begin
                        nxt_sg = SG_BUS;
                        nxt_sreq = INSTR.single;
                        unique case (INSTR.single.ptr)
                            2'h0: nxt_iaddr = PTR_X; // RULE_11 RULE_12
                            2'h1: nxt_iaddr = PTR_A;
                            default: nxt_iaddr = PTR_B;
                        endcase
                        nxt_iwdata = reg_read(INSTR.single.reg_sel, xin_ff[0], xin_ff[1],
                            yin_ff[0], yin_ff[1], mul_ff[0], mul_ff[1], acc_ff[0], acc_ff[1]);
                        if (!INSTR.single.longword) begin
                            if (INSTR.single.reg_sel == DOT_R_GRD0 ||
                                INSTR.single.reg_sel == DOT_R_GRD1) begin
                                nxt_iwdata = {16'h0000, nxt_iwdata[15:0]};
                            end else begin
                                nxt_iwdata = {16'h0000, nxt_iwdata[31:16]}; // RULE_15
                            end
                        end
                    end
                end
            end
            SG_BUS: begin
                // waits for the fetch arbiter to release the bus
                if (I_GRANT) begin // RULE_14
                    nxt_sg = SG_IDLE;
                    nxt_idone = 1'b1;
                end
            end
        endcase
    end

    assign I_REQ = (sg_ff == SG_BUS);
    assign I_WE = I_REQ && !sreq_ff.load;
    assign I_LONG = sreq_ff.longword;
    assign I_ADDR = iaddr_ff;
    assign I_WDATA = iwdata_ff;
    assign I_DONE = idone_ff;
    assign ILLEGAL = ill_ff;

    // --------------------------------------------------------------
    // register file next state
    // --------------------------------------------------------------
    always_comb begin
        logic ldone;
        ldone = (sg_ff == SG_BUS) && I_GRANT && sreq_ff.load;
        nxt_xin = xin_ff;
        nxt_yin = yin_ff;
        nxt_mul = mul_ff;
        nxt_acc = acc_ff;
        nxt_xload = X_REQ && !X_WE;
        nxt_yload = Y_REQ && !Y_WE;
        nxt_xsel = INSTR.x.sel;
        nxt_ysel = INSTR.y.sel;
        // alu writes first so a contended load wins; result undefined anyway
        if (ALU_WE) begin // RULE_21
            unique case (ALU_DST)
                DOT_R_XIN0: nxt_xin[0] = ALU_DATA;
                DOT_R_XIN1: nxt_xin[1] = ALU_DATA;
                DOT_R_YIN0: nxt_yin[0] = ALU_DATA;
                DOT_R_YIN1: nxt_yin[1] = ALU_DATA;
                DOT_R_MUL0: nxt_mul[0] = ALU_DATA;
                DOT_R_MUL1: nxt_mul[1] = ALU_DATA;
                DOT_R_ACC0: nxt_acc[0] = '{{8{ALU_DATA[31]}}, ALU_DATA};
                DOT_R_ACC1: nxt_acc[1] = '{{8{ALU_DATA[31]}}, ALU_DATA};
                default: ;
            endcase
        end
        // memory data arrives one cycle after request; x and y together
        if (xload_ff) begin
            nxt_xin[xsel_ff] = {X_RDATA, 16'h0000}; // RULE_05 RULE_07 RULE_23
        end
        if (yload_ff) begin
            nxt_yin[ysel_ff] = {Y_RDATA, 16'h0000}; // RULE_05 RULE_07 RULE_23
        end
        if (ldone) begin // RULE_13
            unique case (sreq_ff.reg_sel)
                DOT_R_XIN0: nxt_xin[0] = ld_val;
                DOT_R_XIN1: nxt_xin[1] = ld_val;
                DOT_R_YIN0: nxt_yin[0] = ld_val;
                DOT_R_YIN1: nxt_yin[1] = ld_val;
                DOT_R_MUL0: nxt_mul[0] = ld_val;
                DOT_R_MUL1: nxt_mul[1] = ld_val;
                DOT_R_ACC0: nxt_acc[0] = '{ld_guard, ld_val}; // RULE_15 RULE_16
                DOT_R_ACC1: nxt_acc[1] = '{ld_guard, ld_val};
                DOT_R_GRD0: nxt_acc[0].guard = I_RDATA[7:0]; // RULE_18
                DOT_R_GRD1: nxt_acc[1].guard = I_RDATA[7:0]; // RULE_18
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int i = 0; i < 2; i++) begin
                xin_ff[i] <= `DOT_RESET_REG;
                yin_ff[i] <= `DOT_RESET_REG;
                mul_ff[i] <= `DOT_RESET_REG;
                acc_ff[i] <= '{`DOT_RESET_GUARD, `DOT_RESET_REG};
            end
            xload_ff <= 1'b0;
            yload_ff <= 1'b0;
            xsel_ff <= 1'b0;
            ysel_ff <= 1'b0;
            sg_ff <= SG_IDLE;
            sreq_ff <= '0;
            iaddr_ff <= 32'h00000000;
            iwdata_ff <= 32'h00000000;
            idone_ff <= 1'b0;
            ill_ff <= 1'b0;
        end else begin
            xin_ff <= nxt_xin;
            yin_ff <= nxt_yin;
            mul_ff <= nxt_mul;
            acc_ff <= nxt_acc;
            xload_ff <= nxt_xload;
            yload_ff <= nxt_yload;
            xsel_ff <= nxt_xsel;
            ysel_ff <= nxt_ysel;
            sg_ff <= nxt_sg;
            sreq_ff <= nxt_sreq;
            iaddr_ff <= nxt_iaddr;
            iwdata_ff <= nxt_iwdata;
            idone_ff <= nxt_idone;
            ill_ff <= nxt_ill;
        end
    end

    // no status bits are held or driven here
    assign XIN0 = xin_ff[0]; // RULE_02
    assign XIN1 = xin_ff[1];
    assign YIN0 = yin_ff[0];
    assign YIN1 = yin_ff[1];
    assign MUL0 = mul_ff[0];
    assign MUL1 = mul_ff[1];
    assign ACC0 = acc_ff[0];
    assign ACC1 = acc_ff[1];
endmodule // dot_unit

/* File: verif/dot_unit_assertions.sv */
// checker for the dsp operand transfer unit
`timescale 1ns/1ps
module dot_unit_chk
    import dot_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire dot_instr_t INSTR,
    input wire logic STALL,
    input wire logic X_REQ,
    input wire logic X_WE,
    input wire logic [15:0] X_WDATA,
    input wire logic [15:0] X_RDATA,
    input wire logic Y_REQ,
    input wire logic I_REQ,
    input wire logic I_GRANT,
    input wire logic I_DONE,
    input wire logic ILLEGAL,
    input wire logic [31:0] XIN0,
    input wire dot_acc_t ACC0
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);
    logic take;
    logic bad;
    assign take = INSTR.valid && !STALL && !I_REQ && !I_DONE;
    assign bad = INSTR.single.reg_sel >= DOT_R_STATUS || INSTR.single.ptr == 2'h3;
    AST_XY_BOTH: assert property (
        take && !INSTR.single.valid && INSTR.x.dir != DOT_XY_NONE
        && INSTR.y.dir != DOT_XY_NONE |-> X_REQ && Y_REQ) else $error("xy pair split");
    AST_XREQ_CAUSE: assert property (
        X_REQ |-> INSTR.valid && !INSTR.single.valid && INSTR.x.dir != DOT_XY_NONE)
        else $error("x request without x transfer");
    AST_STORE_UPPER: assert property (
        X_REQ && X_WE && !INSTR.x.sel |-> X_WDATA == ACC0.data[31:16])
        else $error("x store data not accumulator upper word");
    AST_LOAD_FILL: assert property (
        X_REQ && !X_WE && !INSTR.x.sel |=> ##1 XIN0 == {$past(X_RDATA), 16'h0000})
        else $error("x load not in upper word with zero low");
    AST_STALL_AFTER_OP: assert property (
        take && INSTR.dataop && !INSTR.single.valid ##1 INSTR.valid && !INSTR.single.valid
        && INSTR.x.dir == DOT_XY_STORE |-> STALL) else $error("store after op not stalled");
    AST_STALL_ONCE: assert property (
        STALL |=> !STALL) else $error("stall longer than one cycle");
    AST_GRANT_DONE: assert property (
        I_REQ && I_GRANT |=> I_DONE && !I_REQ) else $error("grant not completing");
    AST_SINGLE_BUS: assert property (
        I_REQ |-> !X_REQ && !Y_REQ) else $error("xy traffic beside single transfer");
    AST_SINGLE_START: assert property (
        take && INSTR.single.valid && !bad |=> I_REQ && !ILLEGAL)
        else $error("single transfer not started");
    AST_SINGLE_BAD: assert property (
        take && INSTR.single.valid && bad |=> ILLEGAL && !I_REQ ##1 !ILLEGAL)
        else $error("forbidden single transfer not refused");
    COV_STALL: cover property (STALL);
    COV_PAIR: cover property (X_REQ && Y_REQ);
    COV_GRANT: cover property (I_REQ && I_GRANT);
    COV_BAD: cover property (ILLEGAL);
endmodule // dot_unit_chk

bind dot_unit dot_unit_chk u_chk (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .INSTR(INSTR),
    .STALL(STALL), .X_REQ(X_REQ), .X_WE(X_WE), .X_WDATA(X_WDATA), .X_RDATA(X_RDATA),
    .Y_REQ(Y_REQ), .I_REQ(I_REQ), .I_GRANT(I_GRANT), .I_DONE(I_DONE),
    .ILLEGAL(ILLEGAL), .XIN0(XIN0), .ACC0(ACC0));

/* File: verif/dot_mem_model.sv */
// x/y memories and internal bus slave facing the transfer unit
`timescale 1ns/1ps
module dot_mem_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] dly,
    input wire logic x_req,
    input wire logic x_we,
    input wire logic [15:0] x_addr,
    input wire logic [15:0] x_wdata,
    output logic [15:0] x_rdata,
    input wire logic y_req,
    input wire logic y_we,
    input wire logic [15:0] y_addr,
    input wire logic [15:0] y_wdata,
    output logic [15:0] y_rdata,
    input wire logic i_req,
    input wire logic i_we,
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_wdata,
    output logic i_grant,
    output logic [31:0] i_rdata
);
    logic [15:0] xm [16];
    logic [15:0] ym [16];
    logic [31:0] im [16];
    logic [3:0] wcnt;
    logic gnt;
    // fetches hold the bus for dly cycles before a data grant
    assign gnt = i_req && !i_grant && wcnt >= dly;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < 16; k++) begin
                xm[k] <= 16'(k) * 16'h1111;
                ym[k] <= ~(16'(k) * 16'h1111);
                im[k] <= 32'(k) * 32'h11111111;
            end
            x_rdata <= 16'h0000;
            y_rdata <= 16'h0000;
            i_rdata <= 32'h00000000;
            i_grant <= 1'b0;
            wcnt <= 4'h0;
        end else begin
            // data valid one cycle only, scrambled otherwise
            x_rdata <= (x_req && !x_we) ? xm[x_addr[3:0]] : ~x_rdata;
            y_rdata <= (y_req && !y_we) ? ym[y_addr[3:0]] : ~y_rdata;
            if (x_req && x_we) xm[x_addr[3:0]] <= x_wdata;
            if (y_req && y_we) ym[y_addr[3:0]] <= y_wdata;
            i_grant <= gnt;
            wcnt <= (i_req && !i_grant) ? wcnt + 4'h1 : 4'h0;
            i_rdata <= gnt ? im[i_addr[3:0]] : ~i_rdata;
            if (i_req && i_grant && i_we) im[i_addr[3:0]] <= i_wdata;
        end
    end
endmodule // dot_mem_model

/* File: verif/dot_unit_bench.sv */
// self-checking bench for the dsp operand transfer unit
`timescale 1ns/1ps
module dot_unit_bench
    import dot_pkg::*;
;
    logic clk, rst_n, stall, xr, xw, yr, yw, ir, iw, il, ig, idn, ill, aw;
    logic [15:0] xa, xd, xq, ya, yd, yq;
    logic [31:0] px, pa, pb, ia, id, iq, av, x0, x1, y0, y1, wd, m0, m1;
    logic [3:0] dly;
    logic [1:0] fin;
    dot_instr_t ins;
    dot_reg_t adst;
    dot_acc_t a0, a1;
    int num_errors, cmp_count, cycles, st;
    logic [15:0] xs [16];
    logic [15:0] ys [16];
    logic [31:0] rx [4];
    logic [15:0] au [2];
    dot_instr_t rows [11];
    logic [1:0] flg [11];
    dot_unit dut (.CLK_SYS(clk), .RESET_N(rst_n), .INSTR(ins), .STALL(stall),
        .X_REQ(xr), .X_WE(xw), .X_ADDR(xa), .X_WDATA(xd), .X_RDATA(xq),
        .Y_REQ(yr), .Y_WE(yw), .Y_ADDR(ya), .Y_WDATA(yd), .Y_RDATA(yq),
        .PTR_X(px), .PTR_A(pa), .PTR_B(pb), .I_REQ(ir), .I_WE(iw), .I_LONG(il),
        .I_ADDR(ia), .I_WDATA(id), .I_GRANT(ig), .I_RDATA(iq), .I_DONE(idn),
        .ILLEGAL(ill), .ALU_WE(aw), .ALU_DST(adst), .ALU_DATA(av), .XIN0(x0),
        .XIN1(x1), .YIN0(y0), .YIN1(y1), .MUL0(m0), .MUL1(m1), .ACC0(a0), .ACC1(a1));
    dot_mem_model u_mem (.clk(clk), .rst_n(rst_n), .dly(dly), .x_req(xr), .x_we(xw),
        .x_addr(xa), .x_wdata(xd), .x_rdata(xq), .y_req(yr), .y_we(yw), .y_addr(ya),
        .y_wdata(yd), .y_rdata(yq), .i_req(ir), .i_we(iw), .i_addr(ia), .i_wdata(id),
        .i_grant(ig), .i_rdata(iq));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ----
    // helpers
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        if (num_errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            complete_run();
        end
    end
    function automatic dot_instr_t xy(dot_dir_t xdir, logic xsel, logic [3:0] xad,
        dot_dir_t ydir, logic ysel, logic [3:0] yad, logic [2:0] f);
        xy = '0;
        xy.valid = 1'b1;
        xy.x = '{dir: xdir, sel: xsel, addr: 16'(xad)};
        xy.y = '{dir: ydir, sel: ysel, addr: 16'(yad)};
        {xy.parallel, xy.cond_false, xy.dataop} = f;
    endfunction
    // called on a clock edge; returns on the edge that takes the instruction
    task automatic issue(input dot_instr_t i, output int ns);
        ins <= i;
        ns = 0;
        #1;
        while (stall && ns < 8) begin
            ns++;
            @(posedge clk);
            #1;
        end
        if (!i.single.valid) begin
            if (i.x.dir == DOT_XY_STORE) begin
                check(32'(xd), 32'(au[i.x.sel]));
                xs[i.x.addr[3:0]] = au[i.x.sel];
            end
            if (i.y.dir == DOT_XY_STORE) begin
                check(32'(yd), 32'(au[i.y.sel]));
                ys[i.y.addr[3:0]] = au[i.y.sel];
            end
            if (i.x.dir == DOT_XY_LOAD) rx[{1'b0, i.x.sel}] = {xs[i.x.addr[3:0]], 16'h0000};
            if (i.y.dir == DOT_XY_LOAD) rx[{1'b1, i.y.sel}] = {ys[i.y.addr[3:0]], 16'h0000};
        end
        @(posedge clk);
    endtask
    task automatic alu(input dot_reg_t d, input logic [31:0] v);
        aw <= 1'b1;
        adst <= d;
        av <= v;
        @(posedge clk);
        aw <= 1'b0;
        @(posedge clk);
    endtask
    task automatic sgl(input logic ld, input logic lw, input logic [1:0] p, input dot_reg_t r);
        dot_instr_t i;
        int ns;
        i = '0;
        i.valid = 1'b1;
        i.single = '{1'b1, ld, lw, p, r};
        i.x.dir = DOT_XY_LOAD;
        issue(i, ns);
        ins <= '0;
        fin = 2'b00;
        for (int k = 0; k < 20 && fin == 2'b00; k++) begin
            #1;
            if (ir) begin
                wd = id;
                check(32'({il, iw}), 32'({lw, !ld}));
            end
            fin = {idn, ill};
            @(posedge clk);
        end
        check(32'(fin != 2'b00), 32'h1);
        @(posedge clk);
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        {rst_n, aw, cycles, num_errors, cmp_count} = '0;
        {ins, av, px, pa, pb, dly, wd} = '0;
        adst = DOT_R_XIN0;
        for (int k = 0; k < 16; k++) begin
            xs[k] = 16'(k) * 16'h1111;
            ys[k] = ~(16'(k) * 16'h1111);
        end
        rx = '{default: 32'h00000000};
        rows = '{xy(DOT_XY_LOAD, 0, 3, DOT_XY_NONE, 0, 0, 3'h0),
            xy(DOT_XY_NONE, 0, 0, DOT_XY_LOAD, 1, 2, 3'h0),
            xy(DOT_XY_LOAD, 1, 9, DOT_XY_LOAD, 0, 14, 3'h0),
            xy(DOT_XY_LOAD, 0, 10, DOT_XY_NONE, 0, 0, 3'h7),
            xy(DOT_XY_STORE, 0, 3, DOT_XY_NONE, 0, 0, 3'h0),
            xy(DOT_XY_NONE, 0, 0, DOT_XY_STORE, 1, 7, 3'h4),
            xy(DOT_XY_LOAD, 1, 3, DOT_XY_LOAD, 1, 7, 3'h0),
            xy(DOT_XY_STORE, 1, 4, DOT_XY_STORE, 0, 5, 3'h5),
            xy(DOT_XY_LOAD, 0, 4, DOT_XY_NONE, 0, 0, 3'h1),
            xy(DOT_XY_LOAD, 1, 5, DOT_XY_NONE, 0, 0, 3'h0),
            xy(DOT_XY_STORE, 0, 6, DOT_XY_NONE, 0, 0, 3'h0)};
        // stall expected, next row follows back to back
        flg = '{2'b00, 2'b00, 2'b00, 2'b01, 2'b10, 2'b00, 2'b00, 2'b00, 2'b01, 2'b01, 2'b00};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        check(x0, 32'h00000000);
        check(a0.data, 32'h00000000);
        @(posedge clk);
        // accumulators set apart from loads, no shared destination
        alu(DOT_R_ACC0, 32'h89ABCDEF);
        alu(DOT_R_ACC1, 32'h12345678);
        au = '{16'h89AB, 16'h1234};
        foreach (rows[r]) begin
            issue(rows[r], st);
            check(32'(st), 32'(flg[r][1]));
            if (!flg[r][0]) begin
                ins <= '0;
                @(posedge clk);
                #1;
                check(x0, rx[0]);
                check(x1, rx[1]);
                check(y0, rx[2]);
                check(y1, rx[3]);
                @(posedge clk);
            end
        end
        px <= 32'h00000002;
        pa <= 32'h00000009;
        pb <= 32'h0000000C;
        sgl(1'b1, 1'b0, 2'h1, DOT_R_ACC1);
        check(32'(fin), 32'h2);
        check(a1.data, 32'h99990000);
        check(32'(a1.guard), 32'hFF);
        dly <= 4'h3;
        sgl(1'b1, 1'b1, 2'h2, DOT_R_ACC0);
        check(a0.data, 32'hCCCCCCCC);
        check(32'(a0.guard), 32'hFF);
        sgl(1'b1, 1'b0, 2'h0, DOT_R_GRD0);
        check(32'(a0.guard), 32'h22);
        check(a0.data, 32'hCCCCCCCC);
        sgl(1'b0, 1'b0, 2'h1, DOT_R_ACC1);
        check(32'(wd[15:0]), 32'h9999);
        sgl(1'b0, 1'b0, 2'h0, DOT_R_GRD0);
        check(32'(wd[7:0]), 32'h22);
        sgl(1'b0, 1'b1, 2'h2, DOT_R_ACC0);
        check(wd, 32'hCCCCCCCC);
        sgl(1'b1, 1'b1, 2'h1, DOT_R_MUL1);
        check(m1, 32'h00009999);
        check(m0, 32'h00000000);
        sgl(1'b1, 1'b0, 2'h3, DOT_R_XIN0);
        check(32'(fin), 32'h1);
        sgl(1'b0, 1'b1, 2'h0, DOT_R_STATUS);
        check(32'(fin), 32'h1);
        complete_run();
    end
endmodule // dot_unit_bench
